//--- hdl/tti_bank_if.sv
`timescale 1ns/1ps
interface tti_bank_if;
   logic wr;
   logic [1:0] kind;
   logic [1:0] idx;
   logic [31:0] wdata;
   logic [95:0] en;
   logic [95:0] pend;
   modport ctl (output wr, kind, idx, wdata, input en, pend);
   modport bank (input wr, kind, idx, wdata, output en, pend);
endinterface

//--- hdl/tti_irq_bank.sv
`timescale 1ns/1ps
module tti_irq_bank
   import tti_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [IRQ_NUM-1:0] src,
   tti_bank_if.bank bk
);
   typedef struct packed {
      logic [95:0] en;
      logic [95:0] pend;
   } tti_bank_s;
   tti_bank_s st_ff;
   tti_bank_s nxt_st;
   logic [95:0] wmask;

   // place the written word, drop unimplemented positions
   assign wmask = (96'(bk.wdata) << {bk.idx, 5'h00}) & IRQ_IMPL_MASK;

   // four operations per source share one enable and one pending flag
   always_comb begin
      nxt_st = st_ff;
      if (bk.wr) begin
         case (bk.kind)
            BK_SET_EN: nxt_st.en = st_ff.en | wmask;
            BK_CLR_EN: nxt_st.en = st_ff.en & ~wmask;
            BK_SET_PD: nxt_st.pend = st_ff.pend | wmask;
            BK_CLR_PD: nxt_st.pend = st_ff.pend & ~wmask;
            default: nxt_st.en = st_ff.en;
         endcase
      end
      // a source level wins over a clear in the same cycle
      nxt_st.pend = nxt_st.pend | ({18'h00000, src} & IRQ_IMPL_MASK);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bk.en = st_ff.en;
   assign bk.pend = st_ff.pend;
endmodule

//--- hdl/tti_pkg.sv
// Notes on behaviour
// - counter read gives 24-bit value, upper zero
// - any counter write forces value zero
// - counter write also clears counted-to-zero flag
// - calibration bit 31 reports missing reference
// - calibration bit 30 reports inexact 10 ms
// - calibration low bits hold 0x9C4, 29-24 zero
// - four control bits per interrupt source
// - one enable bit per source 0 to 77; positions zero in IRQ_IMPL_MASK stay zero
// - writing one sets the enable
// - writing zero leaves enables untouched
// - set-enable read returns enable state
// - only clear-enable write of one disables
// - flag sets at zero, clears on read
// - counter reloads each time zero reached
// - enabling loads reload value then counts
// - select bit picks reference or cpu clock
package tti_pkg;
   localparam int ADDR_W = 12;
   // register byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h010;
   localparam logic [11:0] ADDR_RELOAD = 12'h014;
   localparam logic [11:0] ADDR_CUR = 12'h018;
   localparam logic [11:0] ADDR_CALIB = 12'h01C;
   localparam logic [11:0] ADDR_IST = 12'h030;
   localparam logic [11:0] ADDR_IMSK = 12'h034;
   localparam logic [11:0] ADDR_SEN1 = 12'h100;
   localparam logic [11:0] ADDR_SEN2 = 12'h104;
   localparam logic [11:0] ADDR_CEN1 = 12'h180;
   // control and status field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_IE_BIT = 1;
   localparam int CTRL_SEL_BIT = 2;
   localparam int CTRL_FLAG_BIT = 16;
   localparam int CAL_NO_REFERENCE_CLOCK_FLAG_BIT = 31;
   localparam int CAL_INEXACT_BIT = 30;
   localparam int IST_ZERO_BIT = 0;
   localparam int IST_CLR_BIT = 1;
   // calibration contents
   localparam logic CAL_NO_REF = 1'b0;
   localparam logic CAL_INEXACT = 1'b0;
   localparam logic [23:0] TEN_MS_COUNT = 24'h0009C4;
   // reference clock divider and interrupt sources
   localparam int REF_DIV_RATIO = 32;
   localparam int IRQ_NUM = 78;
   localparam logic [95:0] IRQ_IMPL_MASK = {32'h00003FFC, 32'h3D7FDFFF, 32'hCFFA47FF};
   // bank operation kinds
   localparam logic [1:0] BK_SET_EN = 2'h0;
   localparam logic [1:0] BK_CLR_EN = 2'h1;
   localparam logic [1:0] BK_SET_PD = 2'h2;
   localparam logic [1:0] BK_CLR_PD = 2'h3;
endpackage

//--- hdl/tti_ref_div.sv
`timescale 1ns/1ps
module tti_ref_div
   import tti_pkg::*;
#(
   parameter int DIV = REF_DIV_RATIO
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ref_in,
   output logic tick
);
   localparam int CW = $clog2(DIV);
   typedef struct packed {
      logic armed;
      logic ref_q;
      logic [CW-1:0] cnt;
      logic tick;
   } tti_div_s;
   tti_div_s st_ff;
   tti_div_s nxt_st;

   // one tick every DIV rising edges of the reference
   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      nxt_st.ref_q = ref_in;
      // the first sample after reset only primes the edge detector
      nxt_st.armed = 1'b1;
      if (st_ff.armed && ref_in && !st_ff.ref_q) begin
         if (st_ff.cnt == CW'(DIV - 1)) begin
            nxt_st.cnt = '0;
            nxt_st.tick = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick = st_ff.tick;
endmodule

//--- hdl/tti_top.sv
`timescale 1ns/1ps
module tti_top
   import tti_pkg::*;
#(
   parameter int REF_DIV = REF_DIV_RATIO
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ref_clk_in,
   input wire logic [IRQ_NUM-1:0] irq_src,
   output logic [IRQ_NUM-1:0] irq_enable,
   output logic [IRQ_NUM-1:0] irq_pending,
   output logic tick_pend,
   output logic irq
);
   typedef struct packed {
      logic tmr_en;
      logic tick_ie;
      logic clk_sel;
      logic cnt_flag;
      logic [23:0] cur;
      logic [23:0] reload;
      logic [31:0] rdata;
      logic [1:0] sts;
      logic [1:0] msk;
      logic tick_pend;
   } tti_state_s;

   tti_state_s st_ff;
   tti_state_s nxt_st;
   tti_bank_if bk ();
   logic ref_tick;
   logic strobe;
   logic zero_evt;
   logic rd_setup;
   logic rd_ctrl;
   logic wr_acc;
   logic [31:0] rd_word;

   ////////////////////////////////////////////////////////////////////////
   // address helpers

   // interrupt bank window: four groups of three words
   function automatic logic bank_hit(input logic [ADDR_W-1:0] a);
      bank_hit = (a[11:8] == 4'h1 || a[11:8] == 4'h2) && a[6:4] == 3'h0 &&
                 a[3:2] != 2'h3 && a[1:0] == 2'h0;
   endfunction

   // any mapped register
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      case (a)
         ADDR_CTRL, ADDR_RELOAD, ADDR_CUR, ADDR_CALIB, ADDR_IST, ADDR_IMSK:
            reg_hit = 1'b1;
         default: reg_hit = bank_hit(a);
      endcase
   endfunction

   // pick one 32-bit word of a 96-bit flag vector
   function automatic logic [31:0] word_of(input logic [95:0] v, input logic [1:0] i);
      word_of = v[{i, 5'h00} +: 32];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // submodules

   // reference clock divided down to counting strobes
   tti_ref_div #(
      .DIV(REF_DIV)
   ) u_div (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ref_in(ref_clk_in),
      .tick(ref_tick)
   );

   // per-source enable and pending flags
   tti_irq_bank u_bank (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .src(irq_src),
      .bk(bk.bank)
   );

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   // slave always ready, unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !reg_hit(paddr);
   assign rd_setup = psel && !penable && !pwrite;
   assign rd_ctrl = rd_setup && paddr == ADDR_CTRL;
   assign wr_acc = psel && penable && pwrite;

   // bank writes travel over the interface
   assign bk.wr = wr_acc && bank_hit(paddr);
   assign bk.kind = {paddr[9], paddr[7]};
   assign bk.idx = paddr[3:2];
   assign bk.wdata = pwdata;

   ////////////////////////////////////////////////////////////////////////
   // timer strobes

   // select bit picks the counting edge source
   assign strobe = st_ff.clk_sel ? 1'b1 : ref_tick;
   assign zero_evt = st_ff.tmr_en && strobe && st_ff.cur == 24'h000001;

   ////////////////////////////////////////////////////////////////////////
   // read mux

   always_comb begin
      rd_word = '0;
      case (paddr)
         ADDR_CTRL: begin
            rd_word[CTRL_EN_BIT] = st_ff.tmr_en;
            rd_word[CTRL_IE_BIT] = st_ff.tick_ie;
            rd_word[CTRL_SEL_BIT] = st_ff.clk_sel;
            rd_word[CTRL_FLAG_BIT] = st_ff.cnt_flag;
         end
         ADDR_RELOAD: rd_word[23:0] = st_ff.reload;
         ADDR_CUR: rd_word[23:0] = st_ff.cur;
         ADDR_CALIB: begin
            rd_word[CAL_NO_REFERENCE_CLOCK_FLAG_BIT] = CAL_NO_REF;
            rd_word[CAL_INEXACT_BIT] = CAL_INEXACT;
            rd_word[23:0] = TEN_MS_COUNT;
         end
         ADDR_IST: rd_word[1:0] = st_ff.sts;
         ADDR_IMSK: rd_word[1:0] = st_ff.msk;
         default: begin
            if (bank_hit(paddr)) begin
               if (paddr[9]) begin
                  rd_word = word_of(bk.pend, paddr[3:2]);
               end else begin
                  rd_word = word_of(bk.en, paddr[3:2]);
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick_pend = 1'b0;
      // count down, reload on zero
      if (st_ff.tmr_en && strobe) begin
         if (st_ff.cur == 24'h000000) begin
            nxt_st.cur = st_ff.reload;
         end else begin
            nxt_st.cur = st_ff.cur - 24'h000001;
         end
      end
      // register writes take effect at the access edge
      if (wr_acc) begin
         case (paddr)
            ADDR_CTRL: begin
               nxt_st.tmr_en = pwdata[CTRL_EN_BIT];
               nxt_st.tick_ie = pwdata[CTRL_IE_BIT];
               nxt_st.clk_sel = pwdata[CTRL_SEL_BIT];
               if (pwdata[CTRL_EN_BIT] && !st_ff.tmr_en) begin
                  nxt_st.cur = st_ff.reload;
               end
            end
            ADDR_RELOAD: nxt_st.reload = pwdata[23:0];
            ADDR_CUR: begin
               nxt_st.cur = 24'h000000;
               nxt_st.cnt_flag = 1'b0;
            end
            ADDR_IST: nxt_st.sts = st_ff.sts & ~pwdata[1:0];
            ADDR_IMSK: nxt_st.msk = pwdata[1:0];
            default: nxt_st.msk = st_ff.msk;
         endcase
      end
      // flag clears when control is read
      if (rd_ctrl) begin
         nxt_st.cnt_flag = 1'b0;
      end
      // events win over clears in the same cycle
      if (zero_evt) begin
         nxt_st.cnt_flag = 1'b1;
         nxt_st.sts[IST_ZERO_BIT] = 1'b1;
         nxt_st.tick_pend = st_ff.tick_ie;
      end
      if (wr_acc && paddr == ADDR_CUR) begin
         nxt_st.sts[IST_CLR_BIT] = 1'b1;
      end
      // read data latched in the setup cycle
      if (rd_setup) begin
         nxt_st.rdata = rd_word;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata = st_ff.rdata;
   assign tick_pend = st_ff.tick_pend;
   assign irq = |(st_ff.sts & st_ff.msk);
   assign irq_enable = bk.en[IRQ_NUM-1:0];
   assign irq_pending = bk.pend[IRQ_NUM-1:0];

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_ctrl_on;
      wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_EN_BIT] && !st_ff.tmr_en;
   endsequence

   sequence s_cur_wr;
      wr_acc && paddr == ADDR_CUR;
   endsequence

   sequence s_quiet_count;
      st_ff.tmr_en && !wr_acc;
   endsequence

   cur_read_a: assert property (
      rd_setup && paddr == ADDR_CUR |=> prdata == {8'h00, $past(st_ff.cur)})
      else $error("counter read value wrong");

   cur_clear_a: assert property (
      s_cur_wr |=> st_ff.cur == 24'h000000 ##1 st_ff.sts[IST_CLR_BIT])
      else $error("counter not cleared by write");

   flag_wclear_a: assert property (
      s_cur_wr and !zero_evt |=> !st_ff.cnt_flag)
      else $error("flag survived counter write");

   calib_read_a: assert property (
      rd_setup && paddr == ADDR_CALIB |=> prdata == 32'h000009C4)
      else $error("calibration word wrong");

   flag_set_a: assert property (
      zero_evt |=> st_ff.cnt_flag && st_ff.cur == 24'h000000)
      else $error("flag not set at zero");

   flag_rclear_a: assert property (
      rd_ctrl && !zero_evt |=> !st_ff.cnt_flag)
      else $error("flag not cleared by read");

   zero_reload_a: assert property (
      s_quiet_count and strobe && st_ff.cur == 24'h000000
      |=> st_ff.cur == $past(st_ff.reload))
      else $error("no reload at zero");

   enable_load_a: assert property (
      s_ctrl_on |=> st_ff.tmr_en && st_ff.cur == $past(st_ff.reload))
      else $error("enable did not load counter");

   cpu_count_a: assert property (
      s_quiet_count and st_ff.clk_sel && st_ff.cur > 24'h000001
      |=> st_ff.cur == $past(st_ff.cur) - 24'h000001)
      else $error("counter did not decrement");

   ref_hold_a: assert property (
      s_quiet_count and !st_ff.clk_sel && !ref_tick |=> $stable(st_ff.cur))
      else $error("counted without reference edge");

   set_enable_a: assert property (
      wr_acc && paddr == ADDR_SEN1 |=>
      (bk.en[31:0] & $past(pwdata) & IRQ_IMPL_MASK[31:0]) ==
      ($past(pwdata) & IRQ_IMPL_MASK[31:0]))
      else $error("set-enable write ignored");

   zero_write_a: assert property (
      wr_acc && paddr == ADDR_SEN1 && pwdata == 32'h00000000 |=> $stable(bk.en))
      else $error("zero write changed enables");

   clr_enable_a: assert property (
      wr_acc && paddr == ADDR_CEN1 |=> (bk.en[31:0] & $past(pwdata)) == 32'h00000000)
      else $error("clear-enable write ignored");

   en_read_a: assert property (
      rd_setup && paddr == ADDR_SEN2 |=> prdata == $past(bk.en[63:32]))
      else $error("set-enable read wrong");

   unimpl_zero_a: assert property (
      rd_setup && paddr == ADDR_SEN1 |=> (prdata & ~IRQ_IMPL_MASK[31:0]) == 32'h00000000)
      else $error("unimplemented enable bit set");

   // counter holds while stopped, upper bits of a read stay zero
   cur_upper_a: assert property (
      rd_setup && paddr == ADDR_CUR |=> prdata[31:24] == 8'h00)
      else $error("counter read upper bits set");

   count_hold_a: assert property (
      !st_ff.tmr_en && !wr_acc |=> $stable(st_ff.cur))
      else $error("stopped counter moved");

   // zero event and counted-to-zero flag
   zero_status_a: assert property (
      zero_evt |=> st_ff.sts[IST_ZERO_BIT])
      else $error("zero event lost in status");

   tick_pulse_a: assert property (
      zero_evt && st_ff.tick_ie |=> tick_pend)
      else $error("tick request missing");

   tick_quiet_a: assert property (
      !zero_evt |=> !tick_pend)
      else $error("tick request without zero event");

   ctrl_flag_a: assert property (
      rd_ctrl |=> prdata[CTRL_FLAG_BIT] == $past(st_ff.cnt_flag))
      else $error("control read lost flag");

   flag_hold_a: assert property (
      st_ff.cnt_flag && !rd_ctrl && !(wr_acc && paddr == ADDR_CUR) |=> st_ff.cnt_flag)
      else $error("flag dropped without read or clear");

   // enable flags across all three words
   en_keep_a: assert property (
      !(bk.wr && bk.kind == BK_CLR_EN) |=> (bk.en & $past(bk.en)) == $past(bk.en))
      else $error("enable dropped without clear-enable write");

   set_any_a: assert property (
      bk.wr && bk.kind == BK_SET_EN |=>
      (word_of(bk.en, $past(bk.idx)) & $past(bk.wdata)) ==
      ($past(bk.wdata) & word_of(IRQ_IMPL_MASK, $past(bk.idx))))
      else $error("set-enable word ignored");

   clr_any_a: assert property (
      bk.wr && bk.kind == BK_CLR_EN |=>
      (word_of(bk.en, $past(bk.idx)) & $past(bk.wdata)) == 32'h00000000)
      else $error("clear-enable word ignored");

   unimpl_clear_a: assert property (
      (bk.en & ~IRQ_IMPL_MASK) == 96'h0 && (bk.pend & ~IRQ_IMPL_MASK) == 96'h0)
      else $error("unimplemented flag set");
endmodule

//--- tb/tick_timer_irq_enable_regs_test.sv
`timescale 1ns/1ps
module tick_timer_irq_enable_regs_test
   import tti_pkg::*;
();
   localparam int RDIV = 2;
   logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, tick_pend, irq;
   logic ref_clk_in = 1'b0;
   logic err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, w;
   logic [IRQ_NUM-1:0] irq_src, irq_enable, irq_pending;
   logic [95:0] en_exp, pd_exp, en_port, pd_port;
   int mismatches, checks;
   int cyc = 0, last_t = 0, gap = 0;

   assign en_port = {18'h0, irq_enable};
   assign pd_port = {18'h0, irq_pending};

   tti_top #(.REF_DIV(RDIV)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in), .irq_src(irq_src),
      .irq_enable(irq_enable), .irq_pending(irq_pending), .tick_pend(tick_pend), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // reference clock, tick spacing and hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      ref_clk_in <= ~ref_clk_in;
      if (tick_pend === 1'b1) begin
         gap <= cyc - last_t;
         last_t <= cyc;
      end
      if (cyc == 40000) begin
         mismatches = mismatches + 1;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // random source and expected enable words
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [95:0] bank_exp(input logic [95:0] old, input int k,
      input logic [31:0] v, input logic set);
      logic [95:0] m;
      m = '0;
      m[32*k +: 32] = v & IRQ_IMPL_MASK[32*k +: 32];
      return set ? (old | m) : (old & ~m);
   endfunction

   // one apb transfer, then one idle cycle
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_rng(input string n, input logic [31:0] lo, input logic [31:0] hi,
      input logic [31:0] g);
      checks++;
      if ((g >= lo) !== 1'b1 || (g <= hi) !== 1'b1) begin
         mismatches++;
         $display("mismatch %s expected %h..%h seen %h", n, lo, hi, g);
      end
   endtask

   task automatic wait_tick();
      @(posedge sys_clk);
      while (tick_pend !== 1'b1) @(posedge sys_clk);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      int k;
      logic s;
      logic [IRQ_NUM-1:0] src_v;
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      irq_src = '0;
      seed = 32'h7FF7;
      mismatches = 0;
      checks = 0;
      en_exp = '0;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      // calibration is constant and ignores writes
      apb(1'b0, ADDR_CALIB, '0);
      chk("calib", {CAL_NO_REF, CAL_INEXACT, 6'h00, TEN_MS_COUNT}, rd);
      chk("calib err", 32'h0, {31'h0, err});
      seed = lfsr(seed);
      apb(1'b1, ADDR_CALIB, seed);
      apb(1'b0, ADDR_CALIB, '0);
      chk("calib", {CAL_NO_REF, CAL_INEXACT, 6'h00, TEN_MS_COUNT}, rd);
      // set and clear enable words, all ones first, one zero write
      for (int i = 0; i < 12; i++) begin
         k = i % 3;
         seed = lfsr(seed);
         w = (i < 3) ? 32'hFFFFFFFF : ((i == 6) ? 32'h0 : seed);
         s = (i % 4 != 3);
         apb(1'b1, (s ? ADDR_SEN1 : ADDR_CEN1) + 12'(4 * k), w);
         en_exp = bank_exp(en_exp, k, w, s);
         apb(1'b0, ADDR_SEN1 + 12'(4 * k), '0);
         chk("set_en", en_exp[32*k +: 32], rd);
         apb(1'b0, ADDR_CEN1 + 12'(4 * k), '0);
         chk("clr_en", en_exp[32*k +: 32], rd);
         chk("irq_enable", en_exp[32*k +: 32], en_port[32*k +: 32]);
      end
      // pending bits from a source pulse and from the pending words
      seed = lfsr(seed);
      src_v = {seed[13:0], seed, ~seed};
      pd_exp = {18'h0, src_v} & IRQ_IMPL_MASK;
      irq_src <= src_v;
      @(posedge sys_clk);
      irq_src <= '0;
      @(posedge sys_clk);
      for (int j = 0; j < 3; j++) begin
         apb(1'b0, 12'h200 + 12'(4 * j), '0);
         chk("pending", pd_exp[32*j +: 32], rd);
         apb(1'b1, 12'h280 + 12'(4 * j), 32'hFFFFFFFF);
         apb(1'b1, 12'h200 + 12'(4 * j), seed);
         apb(1'b0, 12'h200 + 12'(4 * j), '0);
         chk("pending set", seed & IRQ_IMPL_MASK[32*j +: 32], rd);
         chk("irq_pending", seed & IRQ_IMPL_MASK[32*j +: 32], pd_port[32*j +: 32]);
      end
      // cpu clock, reload of calibration minus one
      apb(1'b1, ADDR_RELOAD, {8'h00, TEN_MS_COUNT - 24'h1});
      apb(1'b1, ADDR_CTRL, 32'h7);
      wait_tick();
      wait_tick();
      @(posedge sys_clk);
      chk("tick period", {8'h00, TEN_MS_COUNT}, 32'(gap));
      // enabling loads the reload value, flag clears on read
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_RELOAD, 32'hFFABCDEF);
      apb(1'b1, ADDR_CTRL, 32'h1);
      apb(1'b0, ADDR_CUR, '0);
      chk_rng("current", 32'h00ABCDED, 32'h00ABCDEF, rd);
      apb(1'b0, ADDR_CTRL, '0);
      chk("ctrl flag", 32'h00010001, rd);
      apb(1'b0, ADDR_CTRL, '0);
      chk("ctrl read clear", 32'h00000001, rd);
      // divided reference clock
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_RELOAD, 32'h3);
      apb(1'b1, ADDR_CTRL, 32'h3);
      wait_tick();
      wait_tick();
      @(posedge sys_clk);
      chk("ref period", 32'(4 * RDIV * 2), 32'(gap));
      // counter write clears value and flag
      apb(1'b1, ADDR_CTRL, 32'h2);
      seed = lfsr(seed);
      apb(1'b1, ADDR_CUR, seed);
      apb(1'b0, ADDR_CUR, '0);
      chk("current cleared", 32'h0, rd);
      apb(1'b0, ADDR_CTRL, '0);
      chk("ctrl after clear", 32'h00000002, rd);
      // status, mask and interrupt line
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b0, ADDR_IST, '0);
      chk("status", 32'h3, rd);
      apb(1'b1, ADDR_IMSK, 32'h1);
      chk("irq on", 32'h1, {31'h0, irq});
      apb(1'b1, ADDR_IST, 32'h1);
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b1, ADDR_IMSK, 32'h3);
      chk("irq second", 32'h1, {31'h0, irq});
      apb(1'b1, ADDR_IST, 32'h2);
      apb(1'b0, ADDR_IST, '0);
      chk("status empty", 32'h0, rd);
      chk("irq off", 32'h0, {31'h0, irq});
      // unmapped address
      apb(1'b1, 12'h3F0, seed);
      chk("unmapped err", 32'h1, {31'h0, err});
      apb(1'b0, 12'h3F0, '0);
      chk("unmapped read", 32'h0, rd);
      test_done();
   end
endmodule
